// ---- hdl/urx_bit_if.sv ----
// Bit timing link between the receiver and its bit period generator
`timescale 1ns/1ps
`default_nettype none
interface urx_bit_if;
  logic restart;
  logic [3:0] prs;
  logic [6:0] div;
  logic sample;
  modport gen (input restart, input prs, input div, output sample);
  modport rx (output restart, output prs, output div, input sample);
endinterface
`default_nettype wire

// ---- hdl/urx_bitgen.sv ----
// Operation clock prescaler and bit period generator of the receive channel
`timescale 1ns/1ps
`default_nettype none
`include "urx_defs.svh"
module urx_bitgen (
  input wire logic pclk,
  input wire logic presetn,
  urx_bit_if.gen bit_io
);
  logic [`URX_PRE_W-1:0] pre;
  logic mck_en;
  logic [7:0] cnt;

  function automatic logic [`URX_PRE_W-1:0] urx_mask(input logic [3:0] prs);
    urx_mask = `URX_PRE_W'((16'h0001 << prs) - 16'h0001);
  endfunction

  // Free running so every channel setting shares one prescale phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre <= '0;
    end else begin
      pre <= pre + `URX_PRE_W'(1);
    end
  end

  assign mck_en = ((pre & urx_mask(bit_io.prs)) == urx_mask(bit_io.prs));

  // Half a bit (k+1 ticks) to the start bit middle, then a full bit of 2k+2 ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      bit_io.sample <= 1'b0;
    end else if (bit_io.restart) begin
      cnt <= {1'b0, bit_io.div}; // R1
      bit_io.sample <= 1'b0;
    end else if (mck_en && cnt == 8'h00) begin
      cnt <= {bit_io.div, 1'b1}; // R15
      bit_io.sample <= 1'b1;
    end else begin
      if (mck_en) begin
        cnt <= cnt - 8'h01;
      end
      bit_io.sample <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/urx_channel.sv ----
// Asynchronous receive channel with error flags and start/stop control on APB
`timescale 1ns/1ps
`default_nettype none
`include "urx_defs.svh"
// Operation
// [R1] After start detection, sample instants come from divider field bits 15 to 9.
// [R2] Frame is good when its stop bit arrives before the final sample instant.
// [R3] Sender rate must stay within the receiver tolerance set by k and frame length.
// [R4] Frame length is start plus data plus optional parity plus stop bits.
// [R5] Software computes rate error as generated over target times 100 minus 100.
// [R6] At 16 MHz software may use divider 51 with suitable prescale.
// [R7] Reading the data register clears buffer full and allows the next character.
// [R8] A reception completing while buffer full is still set flags overrun.
// [R9] Ones written to flag clear register clear matching error flags.
// [R10] Parity or overrun: read data, read status, write status to flag clear.
// [R11] Writing one to the stop trigger clears enable status and halts channel.
// [R12] Writing one to the start trigger sets enable status and runs channel.
// [R13] Framing error: read data, clear status, stop, resynchronise, restart.
// [R14] Stop all channels before changing the clock feeding the unit.
// [R15] Bit rate is operation clock divided by twice divider field plus one.
module urx_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`URX_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic rxd,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic channel_enable_status_bit
);
  urx_bit_if bit_io ();
  urx_pkg::urx_state_type state;
  logic rxd_meta, rxd_sync, rxd_prev;
  logic [6:0] div_field;
  logic [7:0] mode;
  logic [7:0] rx_data;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic par_acc, par_bad, stop_left;
  logic buffer_full_flag, ovr_flag, par_flag, frm_flag;
  logic setup, access, wr, rd, done, len7;
  logic [31:0] rd_val;

  function automatic logic urx_mapped(input logic [`URX_ADDR_W-1:0] a);
    urx_mapped = (a == `URX_OFS_DATA) || (a == `URX_OFS_STATUS) ||
                 (a == `URX_OFS_FLAG_CLEAR) || (a == `URX_OFS_MODE) ||
                 (a == `URX_OFS_START) || (a == `URX_OFS_STOP) || (a == `URX_OFS_ENABLE);
  endfunction

  function automatic logic urx_hit(input logic [`URX_ADDR_W-1:0] a,
                                   input logic [`URX_ADDR_W-1:0] ofs);
    urx_hit = (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Line input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
      rxd_prev <= 1'b1;
    end else begin
      rxd_meta <= rxd;
      rxd_sync <= rxd_meta;
      rxd_prev <= rxd_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait state, answer registered at the setup edge
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;

  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr)
      `URX_OFS_DATA: begin
        rd_val[`URX_DIV_HI:`URX_DIV_LO] = div_field;
        rd_val[7:0] = rx_data;
      end
      `URX_OFS_STATUS: begin
        rd_val[`URX_ST_OVR] = ovr_flag;
        rd_val[`URX_ST_PAR] = par_flag;
        rd_val[`URX_ST_FRM] = frm_flag;
        rd_val[`URX_ST_BFF] = buffer_full_flag;
      end
      `URX_OFS_MODE: begin
        rd_val[7:0] = mode;
      end
      `URX_OFS_ENABLE: begin
        rd_val[`URX_CH_BIT] = channel_enable_status_bit;
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !urx_mapped(paddr);
      prdata <= (setup && !pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  // Divider and mode are meant to change only while the channel is stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_field <= `URX_DIV_RST;
      mode <= `URX_MODE_RST;
    end else if (wr) begin
      if (urx_hit(paddr, `URX_OFS_DATA)) begin
        div_field <= pwdata[`URX_DIV_HI:`URX_DIV_LO];
      end
      if (urx_hit(paddr, `URX_OFS_MODE)) begin
        mode <= pwdata[7:0];
      end
    end
  end

  // Stop wins if both triggers are written in the same access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_enable_status_bit <= 1'b0;
    end else if (wr && urx_hit(paddr, `URX_OFS_STOP) && pwdata[`URX_CH_BIT]) begin
      channel_enable_status_bit <= 1'b0; // R11
    end else if (wr && urx_hit(paddr, `URX_OFS_START) && pwdata[`URX_CH_BIT]) begin
      channel_enable_status_bit <= 1'b1; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit timing
  assign bit_io.restart = (state == urx_pkg::URX_IDLE);
  assign bit_io.prs = mode[`URX_MODE_PRS_HI:0];
  assign bit_io.div = div_field;

  urx_bitgen u_bitgen (
    .pclk(pclk),
    .presetn(presetn),
    .bit_io(bit_io)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Receiver
  assign len7 = mode[`URX_MODE_LEN7];
  assign done = (state == urx_pkg::URX_STOP) && bit_io.sample && !stop_left;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= urx_pkg::URX_IDLE;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      par_acc <= 1'b0;
      par_bad <= 1'b0;
      stop_left <= 1'b0;
    end else if (!channel_enable_status_bit) begin
      state <= urx_pkg::URX_IDLE; // R11
    end else begin
      case (state)
        urx_pkg::URX_IDLE: begin
          if (rxd_prev && !rxd_sync) begin
            state <= urx_pkg::URX_START; // R1
          end
          bit_cnt <= len7 ? 4'h7 : 4'h8; // R4
          par_acc <= 1'b0;
          par_bad <= 1'b0;
          stop_left <= mode[`URX_MODE_STOP2];
        end
        urx_pkg::URX_START: begin
          // A glitch shorter than half a bit is dropped
          if (bit_io.sample) begin
            state <= rxd_sync ? urx_pkg::URX_IDLE : urx_pkg::URX_DATA;
          end
        end
        urx_pkg::URX_DATA: begin
          if (bit_io.sample) begin
            shift <= {rxd_sync, shift[7:1]}; // R3
            par_acc <= par_acc ^ rxd_sync;
            bit_cnt <= bit_cnt - 4'h1;
            if (bit_cnt == 4'h1) begin
              state <= mode[`URX_MODE_PAR_EN] ? urx_pkg::URX_PARITY : urx_pkg::URX_STOP;
            end
          end
        end
        urx_pkg::URX_PARITY: begin
          if (bit_io.sample) begin
            par_bad <= (par_acc ^ rxd_sync) != mode[`URX_MODE_PAR_ODD];
            state <= urx_pkg::URX_STOP;
          end
        end
        urx_pkg::URX_STOP: begin
          if (bit_io.sample) begin
            stop_left <= 1'b0;
            if (!stop_left) begin
              state <= urx_pkg::URX_IDLE; // R2
            end
          end
        end
        default: begin
          state <= urx_pkg::URX_IDLE;
        end
      endcase
    end
  end

  // A held character is kept; the late one is lost and flagged as overrun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data <= 8'h00;
    end else if (done && !buffer_full_flag) begin
      rx_data <= len7 ? {1'b0, shift[7:1]} : shift;
    end
  end

  // Set wins over clear for every flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_full_flag <= 1'b0;
    end else if (done) begin
      buffer_full_flag <= 1'b1;
    end else if (rd && urx_hit(paddr, `URX_OFS_DATA)) begin
      buffer_full_flag <= 1'b0; // R7
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_flag <= 1'b0;
      par_flag <= 1'b0;
      frm_flag <= 1'b0;
    end else begin
      ovr_flag <= (done && buffer_full_flag) || // R8
                  (ovr_flag && !(wr && urx_hit(paddr, `URX_OFS_FLAG_CLEAR) &&
                                 pwdata[`URX_ST_OVR])); // R9
      par_flag <= (done && par_bad) ||
                  (par_flag && !(wr && urx_hit(paddr, `URX_OFS_FLAG_CLEAR) &&
                                 pwdata[`URX_ST_PAR])); // R9
      frm_flag <= (done && !rxd_sync) || // R2
                  (frm_flag && !(wr && urx_hit(paddr, `URX_OFS_FLAG_CLEAR) &&
                                 pwdata[`URX_ST_FRM])); // R9
    end
  end
endmodule
`default_nettype wire

// ---- hdl/urx_defs.svh ----
// Offsets, field positions, reset values and timing constants of the receive channel
`ifndef URX_DEFS_SVH
`define URX_DEFS_SVH
`define URX_ADDR_W 12
`define URX_OFS_DATA 12'h000
`define URX_OFS_STATUS 12'h004
`define URX_OFS_FLAG_CLEAR 12'h008
`define URX_OFS_MODE 12'h00c
`define URX_OFS_START 12'h010
`define URX_OFS_STOP 12'h014
`define URX_OFS_ENABLE 12'h018
`define URX_DIV_HI 15
`define URX_DIV_LO 9
`define URX_ST_OVR 0
`define URX_ST_PAR 1
`define URX_ST_FRM 2
`define URX_ST_BFF 5
`define URX_MODE_PRS_HI 3
`define URX_MODE_PAR_EN 4
`define URX_MODE_PAR_ODD 5
`define URX_MODE_LEN7 6
`define URX_MODE_STOP2 7
`define URX_CH_BIT 0
`define URX_DIV_RST 7'h33
`define URX_MODE_RST 8'h00
`define URX_PRE_W 15
`endif

// ---- hdl/urx_pkg.sv ----
// Types shared by the receive channel modules
package urx_pkg;
  typedef enum logic [2:0] {
    URX_IDLE,
    URX_START,
    URX_DATA,
    URX_PARITY,
    URX_STOP
  } urx_state_type;
endpackage

// ---- test/testbench.sv ----
// Self-checking bench of the receive channel
`timescale 1ns/1ps
`default_nettype none
`include "urx_defs.svh"
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, ena;
  logic [`URX_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [32:0] exp_q[$];
  logic [32:0] exp_w;
  logic [7:0] b0, b1;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  urx_channel u_urx_channel (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rxd(rxd), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channel_enable_status_bit(ena));
  urx_tx_model u_urx_tx_model (.pclk(pclk), .rxd(rxd));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] e);
    n_tests++;
    if (seen !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, e, seen);
    end
  endtask
  // Sender bit length in pclk for divider d at prescale p, zero rate error
  function automatic int bit_len(input int d, input int p);
    return (2 * (d + 1)) << p;
  endfunction
  task automatic complete_run();
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [`URX_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [`URX_ADDR_W-1:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // Read results are compared as {pslverr, prdata}; the pin with each enable read
  always @(posedge pclk) begin
    cyc++;
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
      exp_w = exp_q.pop_front();
      check("read word", {pslverr, prdata}, exp_w);
      if (paddr == `URX_OFS_ENABLE) begin
        check("enable pin", {32'h0, ena}, {32'h0, exp_w[0]});
      end
    end
    if (cyc > 20000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(32'hd20ae175));
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`URX_OFS_DATA, {17'h0, `URX_DIV_RST, 9'h0});
    rd(`URX_OFS_STATUS, 33'h0);
    rd(`URX_OFS_MODE, 33'h0);
    rd(`URX_OFS_ENABLE, 33'h0);
    rd(`URX_OFS_FLAG_CLEAR, 33'h0);
    rd(12'h020, 33'h100000000);
    apb(1'b1, `URX_OFS_DATA, 32'h600);
    apb(1'b1, `URX_OFS_START, 32'h1);
    rd(`URX_OFS_ENABLE, 33'h1);
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    // Divider 3 at prescale 0 gives 8 pclk a bit
    u_urx_tx_model.send(b0, 1'b0, 1'b0, 1'b1, 8);
    rd(`URX_OFS_STATUS, 33'h20);
    rd(`URX_OFS_DATA, {25'h6, b0});
    rd(`URX_OFS_STATUS, 33'h0);
    u_urx_tx_model.send(b0, 1'b0, 1'b0, 1'b1, 8);
    u_urx_tx_model.send(b1, 1'b0, 1'b0, 1'b1, 8);
    rd(`URX_OFS_STATUS, 33'h21);
    rd(`URX_OFS_DATA, {25'h6, b0});
    rd(`URX_OFS_STATUS, 33'h1);
    apb(1'b1, `URX_OFS_FLAG_CLEAR, 32'h1);
    rd(`URX_OFS_STATUS, 33'h0);
    apb(1'b1, `URX_OFS_MODE, 32'h10);
    u_urx_tx_model.send(b1, 1'b1, 1'b1, 1'b1, 8);
    rd(`URX_OFS_STATUS, 33'h22);
    rd(`URX_OFS_DATA, {25'h6, b1});
    apb(1'b1, `URX_OFS_FLAG_CLEAR, 32'h1);
    rd(`URX_OFS_STATUS, 33'h2);
    apb(1'b1, `URX_OFS_FLAG_CLEAR, 32'h2);
    u_urx_tx_model.send(b0, 1'b1, 1'b0, 1'b1, 8);
    rd(`URX_OFS_STATUS, 33'h20);
    rd(`URX_OFS_DATA, {25'h6, b0});
    apb(1'b1, `URX_OFS_MODE, 32'h0);
    u_urx_tx_model.send(b1, 1'b0, 1'b0, 1'b0, 8);
    rd(`URX_OFS_DATA, {25'h6, b1});
    rd(`URX_OFS_STATUS, 33'h4);
    apb(1'b1, `URX_OFS_FLAG_CLEAR, 32'h4);
    apb(1'b1, `URX_OFS_STOP, 32'h1);
    rd(`URX_OFS_ENABLE, 33'h0);
    u_urx_tx_model.send(b0, 1'b0, 1'b0, 1'b1, 8);
    rd(`URX_OFS_STATUS, 33'h0);
    // Divider 5 gives 12 pclk a bit
    apb(1'b1, `URX_OFS_DATA, 32'ha00);
    apb(1'b1, `URX_OFS_START, 32'h1);
    u_urx_tx_model.send(b1, 1'b0, 1'b0, 1'b1, 12);
    rd(`URX_OFS_STATUS, 33'h20);
    rd(`URX_OFS_DATA, {25'ha, b1});
    // Prescale 1, odd parity, 7 data bits, 2 stops: 24 pclk a bit
    apb(1'b1, `URX_OFS_STOP, 32'h1);
    apb(1'b1, `URX_OFS_MODE, 32'hf1);
    apb(1'b1, `URX_OFS_START, 32'h1);
    u_urx_tx_model.send(b0, 1'b1, 1'b0, 1'b1, bit_len(5, 1), 1'b1, 7, 2);
    rd(`URX_OFS_STATUS, 33'h20);
    rd(`URX_OFS_DATA, {25'ha, 1'b0, b0[6:0]});
    // Divider 51 at prescale 0: senders about 4 percent fast and 5 percent slow
    apb(1'b1, `URX_OFS_STOP, 32'h1);
    apb(1'b1, `URX_OFS_MODE, 32'h0);
    apb(1'b1, `URX_OFS_DATA, 32'h6600);
    apb(1'b1, `URX_OFS_START, 32'h1);
    u_urx_tx_model.send(b0, 1'b0, 1'b0, 1'b1, bit_len(51, 0) - 4);
    rd(`URX_OFS_STATUS, 33'h20);
    rd(`URX_OFS_DATA, {25'h66, b0});
    u_urx_tx_model.send(b1, 1'b0, 1'b0, 1'b1, bit_len(51, 0) + 5);
    rd(`URX_OFS_STATUS, 33'h20);
    rd(`URX_OFS_DATA, {25'h66, b1});
    repeat (4) @(posedge pclk);
    complete_run();
  end
endmodule
`default_nettype wire

// ---- test/urx_channel_monitor.sv ----
// Port checks of the receive channel
`timescale 1ns/1ps
`default_nettype none
`include "urx_defs.svh"
module urx_channel_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`URX_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic channel_enable_status_bit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr1 = psel && penable && pready && pwrite && pwdata[0];
  wire logic setup = psel && !penable;
  chk_ready_after_setup: assert property (setup |=> pready)
    else $error("no pready after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready too long");
  chk_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  chk_err_unmapped: assert property (setup &&
    (paddr > `URX_OFS_ENABLE || paddr[1:0] != 2'b00) |=> pslverr && !prdata)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (setup &&
    paddr <= `URX_OFS_ENABLE && paddr[1:0] == 2'b00 |=> !pslverr)
    else $error("mapped access refused");
  chk_start_sets: assert property (
    wr1 && paddr == `URX_OFS_START |=> channel_enable_status_bit)
    else $error("start did not enable");
  chk_stop_clears: assert property (
    wr1 && paddr == `URX_OFS_STOP |=> !channel_enable_status_bit)
    else $error("stop did not disable");
  chk_enable_cause: assert property (
    $changed(channel_enable_status_bit) |-> $past(psel && penable && pready && pwrite))
    else $error("enable moved alone");
  chk_prdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
endmodule
bind urx_channel urx_channel_monitor u_urx_channel_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .channel_enable_status_bit(channel_enable_status_bit));
`default_nettype wire

// ---- test/urx_tx_model.sv ----
// Remote asynchronous sender on the receive line
`timescale 1ns/1ps
`default_nettype none
module urx_tx_model (
  input wire logic pclk,
  output logic rxd
);
  initial rxd = 1'b1;
  // Start, nd data LSB first, optional parity, ns stops; only the last stop carries sv
  task automatic send(input logic [7:0] d, input logic pe, input logic bad, input logic sv,
    input int bc, input logic odd = 1'b0, input int nd = 8, input int ns = 1);
    logic [12:0] f;
    logic par;
    int n;
    f = '1;
    f[0] = 1'b0;
    par = odd ^ bad;
    for (int i = 0; i < nd; i++) begin
      f[i + 1] = d[i];
      par = par ^ d[i];
    end
    if (pe) begin
      f[nd + 1] = par;
    end
    n = 1 + nd + (pe ? 1 : 0) + ns;
    f[n - 1] = sv;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      rxd <= f[i];
      repeat (bc - 1) @(posedge pclk);
    end
    @(posedge pclk);
    rxd <= 1'b1;
  endtask
endmodule
`default_nettype wire
